/* File: rtl/srog_pkg.sv */
// Package of offsets, field layouts and reset values for the output gating bytes
package srog_pkg;
  // Register indices as sent in the command byte
  localparam logic [7:0] IDX_OUT_EN    = 8'h03;
  localparam logic [7:0] IDX_REQ_MAP   = 8'h04;
  localparam logic [7:0] IDX_VSEL_FSEL = 8'h05;
  localparam logic [7:0] IDX_BYTE_CNT  = 8'h08;
  // Writable bits; reserved bits keep their reset value
  localparam logic [7:0] OUT_EN_WMASK  = 8'hF5;
  localparam logic [7:0] REQ_MAP_WMASK = 8'hE7;
  localparam logic [7:0] VSEL_WMASK    = 8'hEF;
  // Reset values
  localparam logic [7:0] OUT_EN_RST    = 8'hFF;
  localparam logic [7:0] REQ_MAP_RST   = 8'h00;
  localparam logic [2:0] VSEL_RST      = 3'h5;
  localparam logic [3:0] FSEL_RST      = 4'h0;
  localparam logic [7:0] BYTE_CNT_RST  = 8'h09;
  // Field positions inside the voltage and frequency byte
  localparam int unsigned VSEL_LSB     = 5;
  localparam int unsigned FSEL_LSB     = 0;
  // Seven-bit bus address; the bit after it selects read or write
  localparam logic [6:0] SLAVE_ADDR    = 7'h69;
  // Bit engine states
  typedef enum logic [2:0] {
    PHY_IDLE = 3'h0,
    PHY_RX   = 3'h1,
    PHY_ACK  = 3'h2,
    PHY_TX   = 3'h3,
    PHY_MACK = 3'h4
  } srog_phy_t;
  // Transaction states
  typedef enum logic [2:0] {
    TR_IDLE = 3'h0,
    TR_ADDR = 3'h1,
    TR_CMD  = 3'h2,
    TR_CNT  = 3'h3,
    TR_DATA = 3'h4,
    TR_READ = 3'h5
  } srog_tr_t;
endpackage

/* File: rtl/srog_smb_phy.sv */
// Bit level engine of the two-wire management bus slave
`timescale 1ns/1ps
`default_nettype none
module srog_smb_phy (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       smb_clk_pin,
  input  wire logic       smb_data_in,
  input  wire logic       ack_en,
  input  wire logic       tx_mode,
  input  wire logic [7:0] tx_byte,
  output logic            smb_data_out,
  output logic            smb_data_oe,
  output logic            start_p,
  output logic            stop_p,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            tx_take
);
  logic [2:0]        scl_q;
  logic [2:0]        sda_q;
  logic              scl_rise;
  logic              scl_fall;
  logic [7:0]        sh;
  logic [3:0]        cnt;
  logic              ack_q;
  logic              mack_ok;
  srog_pkg::srog_phy_t st;

  // Two flops per pin, third only for edge detection
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end
    else
    begin
      scl_q <= {scl_q[1:0], smb_clk_pin};
      sda_q <= {sda_q[1:0], smb_data_in};
    end

  assign scl_rise     = scl_q[1] & ~scl_q[2];
  assign scl_fall     = ~scl_q[1] & scl_q[2];
  assign start_p      = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_p       = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  assign smb_data_out = 1'b0; // Open drain: only ever pulls low

  // Bit sequencing; a start always wins, even mid byte
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      st       <= srog_pkg::PHY_IDLE;
      sh       <= 8'h00;
      cnt      <= 4'h0;
      mack_ok  <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte  <= 8'h00;
      tx_take  <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      tx_take  <= 1'b0;
      if (start_p)
      begin
        st  <= srog_pkg::PHY_RX;
        cnt <= 4'h0;
      end
      else if (stop_p)
        st <= srog_pkg::PHY_IDLE;
      else
        unique case (st)
          srog_pkg::PHY_IDLE: ;
          srog_pkg::PHY_RX:
          begin
            if (scl_rise)
            begin
              sh  <= {sh[6:0], sda_q[1]};
              cnt <= cnt + 4'h1;
              if (cnt == 4'h7)
              begin
                rx_valid <= 1'b1;
                rx_byte  <= {sh[6:0], sda_q[1]};
              end
            end
            if (scl_fall && cnt == 4'h8)
              st <= ack_q ? srog_pkg::PHY_ACK : srog_pkg::PHY_IDLE;
          end
          srog_pkg::PHY_ACK:
            if (scl_fall)
            begin
              cnt <= 4'h0;
              if (tx_mode)
              begin
                st      <= srog_pkg::PHY_TX;
                sh      <= tx_byte;
                tx_take <= 1'b1;
              end
              else
                st <= srog_pkg::PHY_RX;
            end
          srog_pkg::PHY_TX:
          begin
            if (scl_rise)
              cnt <= cnt + 4'h1;
            if (scl_fall)
            begin
              if (cnt == 4'h8)
                st <= srog_pkg::PHY_MACK;
              else
                sh <= {sh[6:0], 1'b0};
            end
          end
          srog_pkg::PHY_MACK:
          begin
            if (scl_rise)
              mack_ok <= ~sda_q[1];
            if (scl_fall)
            begin
              cnt <= 4'h0;
              if (mack_ok)
              begin
                st      <= srog_pkg::PHY_TX;
                sh      <= tx_byte;
                tx_take <= 1'b1;
              end
              else
                st <= srog_pkg::PHY_IDLE;
            end
          end
          default: st <= srog_pkg::PHY_IDLE;
        endcase
    end

  // Ack decision is frozen when the byte completes
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      ack_q <= 1'b0;
    else if (rx_valid)
      ack_q <= ack_en;

  // Registered pull-down; changes one cycle after the state, four cycles after the clock pin falls
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      smb_data_oe <= 1'b0;
    else
      smb_data_oe <= (st == srog_pkg::PHY_ACK) | ((st == srog_pkg::PHY_TX) & ~sh[7]);
endmodule
`default_nettype wire

/* File: rtl/srog_ctrl.sv */
// Output gating control bytes with their management bus slave
`timescale 1ns/1ps
`default_nettype none
module srog_ctrl (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       smb_clk_pin,
  input  wire logic       smb_data_in,
  output logic            smb_data_out,
  output logic            smb_data_oe,
  input  wire logic       request_pin_a_n,
  input  wire logic       request_pin_c_n,
  output logic [5:0]      serial_ref_run,
  output logic [1:0]      graphics_run,
  output logic [2:0]      out_voltage_sel,
  output logic [3:0]      serial_ref_freq_sel
);
  logic [7:0]        serial_ref_output_enables;
  logic [7:0]        request_pin_output_mapping;
  logic [7:0]        voltage_and_serial_ref_freq_select;
  logic [7:0]        byte_count;
  logic [7:0]        index;
  logic [7:0]        wcount;
  logic              reading;
  logic              first_q;
  logic              start_p;
  logic              stop_p;
  logic              rx_valid;
  logic [7:0]        rx_byte;
  logic              tx_take;
  logic [7:0]        tx_byte;
  logic              ack_en;
  logic              reg_wr;
  logic [1:0]        req_a_q;
  logic [1:0]        req_c_q;
  logic              req_a;
  logic              req_c;
  logic [5:0]        en_vec;
  logic [5:0]        map_vec;
  logic [5:0]        req_vec;
  logic [5:0]        next_run;
  logic [1:0]        next_gfx;
  srog_pkg::srog_tr_t ts;

  // Register read decode by index; unused indices read zero
  function automatic logic [7:0] reg_rd(input logic [7:0] idx, input logic [7:0] en,
                                        input logic [7:0] mp, input logic [7:0] vf,
                                        input logic [7:0] bc);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      srog_pkg::IDX_OUT_EN:    v = en;
      srog_pkg::IDX_REQ_MAP:   v = mp;
      srog_pkg::IDX_VSEL_FSEL: v = vf;
      srog_pkg::IDX_BYTE_CNT:  v = bc;
      default:                 v = 8'h00;
    endcase
    return v;
  endfunction

  srog_smb_phy u_phy (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .smb_clk_pin  (smb_clk_pin),
    .smb_data_in  (smb_data_in),
    .ack_en       (ack_en),
    .tx_mode      (reading),
    .tx_byte      (tx_byte),
    .smb_data_out (smb_data_out),
    .smb_data_oe  (smb_data_oe),
    .start_p      (start_p),
    .stop_p       (stop_p),
    .rx_valid     (rx_valid),
    .rx_byte      (rx_byte),
    .tx_take      (tx_take)
  );

  // Only the address byte can be refused
  assign ack_en  = (ts != srog_pkg::TR_IDLE)
                   & ((ts != srog_pkg::TR_ADDR) | (rx_byte[7:1] == srog_pkg::SLAVE_ADDR));
  assign reg_wr  = rx_valid & (ts == srog_pkg::TR_DATA) & (wcount != 8'h00);
  assign tx_byte = first_q ? byte_count
                 : reg_rd(index, serial_ref_output_enables, request_pin_output_mapping,
                          voltage_and_serial_ref_freq_select, byte_count);

  // Transaction sequencing: address, command, count, then data; a read address goes straight to read
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      ts      <= srog_pkg::TR_IDLE;
      index   <= 8'h00;
      wcount  <= 8'h00;
      reading <= 1'b0;
      first_q <= 1'b0;
    end
    else if (start_p)
    begin
      ts      <= srog_pkg::TR_ADDR;
      reading <= 1'b0;
    end
    else if (stop_p)
    begin
      ts      <= srog_pkg::TR_IDLE;
      reading <= 1'b0;
    end
    else if (rx_valid)
      unique case (ts)
        srog_pkg::TR_ADDR:
          if (rx_byte[7:1] != srog_pkg::SLAVE_ADDR)
            ts <= srog_pkg::TR_IDLE;
          else if (rx_byte[0])
          begin
            ts      <= srog_pkg::TR_READ;
            reading <= 1'b1;
            first_q <= 1'b1; // Count goes out ahead of the data
          end
          else
            ts <= srog_pkg::TR_CMD;
        srog_pkg::TR_CMD:
        begin
          index <= rx_byte;
          ts    <= srog_pkg::TR_CNT;
        end
        srog_pkg::TR_CNT:
        begin
          wcount <= rx_byte;
          ts     <= srog_pkg::TR_DATA;
        end
        srog_pkg::TR_DATA:
          if (wcount != 8'h00)
          begin
            index  <= index + 8'h01;
            wcount <= wcount - 8'h01;
          end
        default: ;
      endcase
    else if (tx_take)
    begin
      if (first_q)
        first_q <= 1'b0;
      else
        index <= index + 8'h01;
    end

  // Control bytes; reserved bits are masked so they keep their reset level
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      serial_ref_output_enables  <= srog_pkg::OUT_EN_RST;
      request_pin_output_mapping <= srog_pkg::REQ_MAP_RST;
      voltage_and_serial_ref_freq_select <= {srog_pkg::VSEL_RST, 1'b0,
                                             srog_pkg::FSEL_RST};
      byte_count                 <= srog_pkg::BYTE_CNT_RST;
    end
    else if (reg_wr)
      unique case (index)
        srog_pkg::IDX_OUT_EN:
          serial_ref_output_enables <= (rx_byte & srog_pkg::OUT_EN_WMASK)
                                       | (srog_pkg::OUT_EN_RST & ~srog_pkg::OUT_EN_WMASK);
        srog_pkg::IDX_REQ_MAP:
          request_pin_output_mapping <= rx_byte & srog_pkg::REQ_MAP_WMASK;
        srog_pkg::IDX_VSEL_FSEL:
          voltage_and_serial_ref_freq_select <= rx_byte & srog_pkg::VSEL_WMASK;
        srog_pkg::IDX_BYTE_CNT:
          byte_count <= rx_byte;
        default: ;
      endcase

  assign out_voltage_sel     =
    voltage_and_serial_ref_freq_select[srog_pkg::VSEL_LSB +: 3];
  assign serial_ref_freq_sel =
    voltage_and_serial_ref_freq_select[srog_pkg::FSEL_LSB +: 4];

  // Request pins come from other devices, so synchronise them
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      req_a_q <= 2'h3;
      req_c_q <= 2'h3;
    end
    else
    begin
      req_a_q <= {req_a_q[0], request_pin_a_n};
      req_c_q <= {req_c_q[0], request_pin_c_n};
    end

  assign req_a    = ~req_a_q[1];
  assign req_c    = ~req_c_q[1];
  assign en_vec   = {serial_ref_output_enables[7:4], serial_ref_output_enables[2],
                     serial_ref_output_enables[0]};
  assign map_vec  = {request_pin_output_mapping[7:5], 2'b00, request_pin_output_mapping[0]};
  assign req_vec  = {req_a, req_a, req_a, 2'b00, req_c};
  // Enable gates first, request second
  assign next_run = en_vec & (~map_vec | req_vec);
  assign next_gfx = ~request_pin_output_mapping[2:1] | {req_c, req_c};

  // Registered so an output only toggles on whole cycles, never glitches
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      serial_ref_run <= 6'h3F;
      graphics_run   <= 2'h3;
    end
    else
    begin
      serial_ref_run <= next_run;
      graphics_run   <= next_gfx;
    end

  // Checks
  logic seen;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      seen <= 1'b0;
    else
      seen <= 1'b1;

  AST_RESET_VALUES: assert property (@(posedge sys_clk) disable iff (!rstn)
    !seen |-> (serial_ref_output_enables == 8'hFF) && (request_pin_output_mapping == 8'h00))
    else $error("control bytes not at reset value");
  AST_VSEL_DEFAULT: assert property (@(posedge sys_clk) disable iff (!rstn)
    !seen |-> (out_voltage_sel == 3'h5) && (serial_ref_freq_sel == 4'h0))
    else $error("voltage select not at default");
  AST_MASTER_STOP: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!en_vec[5] && req_a) [*2] |-> !serial_ref_run[5])
    else $error("disabled output runs despite request");
  AST_REQ_GATE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (map_vec[0] && !req_c) [*2] |-> !serial_ref_run[0] && (graphics_run
      == ~$past(request_pin_output_mapping[2:1])))
    else $error("mapped output runs without request");
  AST_RUN_ENABLED: assert property (@(posedge sys_clk) disable iff (!rstn)
    (en_vec[4] && !map_vec[4]) |=> serial_ref_run[4])
    else $error("enabled unmapped output stopped");
  AST_MAP_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (reg_wr && index == srog_pkg::IDX_REQ_MAP)
      |=> request_pin_output_mapping == ($past(rx_byte) & srog_pkg::REQ_MAP_WMASK))
    else $error("mapping byte write lost");
  AST_FSEL_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (reg_wr && index == srog_pkg::IDX_VSEL_FSEL)
      |=> serial_ref_freq_sel == $past(rx_byte[3:0])
      && out_voltage_sel == $past(rx_byte[7:5]))
    else $error("frequency select write lost");
  AST_COUNT_FIRST: assert property (@(posedge sys_clk) disable iff (!rstn)
    (tx_take && first_q) |-> u_phy.sh == byte_count ##1 !first_q)
    else $error("read did not start with byte count");
  AST_READ_BACK: assert property (@(posedge sys_clk) disable iff (!rstn)
    (tx_take && !first_q && index == srog_pkg::IDX_VSEL_FSEL)
      |-> u_phy.sh == voltage_and_serial_ref_freq_select)
    else $error("read back mismatch");

  COV_WRITE_EN: cover property (@(posedge sys_clk) disable iff (!rstn)
    reg_wr && index == 8'h03);
  COV_BLOCK_READ: cover property (@(posedge sys_clk) disable iff (!rstn)
    tx_take && first_q ##[1:1000] tx_take);
  COV_GATED_STOP: cover property (@(posedge sys_clk) disable iff (!rstn)
    $fell(serial_ref_run[0]) && en_vec[0]);
endmodule
`default_nettype wire

/* File: verif/srog_host.sv */
// Bus host model driving the two-wire management bus of the gating bytes
`timescale 1ns/1ps
`default_nettype none
module srog_host (
  input  wire logic sys_clk,
  input  wire logic dut_data_oe,
  output logic      smb_clk_pin,
  output logic      smb_data_in
);
  logic       data_rel;
  int         nacks;
  logic [7:0] rx_buf [0:7];

  // Pulled-up wire: low while either party pulls it
  assign smb_data_in = data_rel & ~dut_data_oe;

  // Idle bus at time zero
  initial
  begin
    smb_clk_pin = 1'b1;
    data_rel = 1'b1;
    nacks = 0;
  end

  // Third of a bit time, far above the 8-cycle minimum between pin edges
  task automatic qtr();
    repeat (20) @(posedge sys_clk);
  endtask

  // One bit: data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    data_rel <= b;
    qtr();
    smb_clk_pin <= 1'b1;
    qtr();
    r = smb_data_in;
    smb_clk_pin <= 1'b0;
    qtr();
  endtask

  // Start or repeated start
  task automatic start_c();
    data_rel <= 1'b1;
    qtr();
    smb_clk_pin <= 1'b1;
    qtr();
    data_rel <= 1'b0;
    qtr();
    smb_clk_pin <= 1'b0;
    qtr();
  endtask

  // Stop: data rises while the clock is high
  task automatic stop_c();
    data_rel <= 1'b0;
    qtr();
    smb_clk_pin <= 1'b1;
    qtr();
    data_rel <= 1'b1;
    qtr();
  endtask

  // Send a byte MSB first; a missing ack is counted
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    if (r)
      nacks++;
  endtask

  // Receive a byte, then ack it or end with a nack
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask

  // Block write of one byte at an index
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    start_c();
    tx({srog_pkg::SLAVE_ADDR, 1'b0});
    tx(idx);
    tx(8'h01);
    tx(d);
    stop_c();
  endtask

  // Block read: count byte, then n register bytes, nack on the last
  task automatic rd(input logic [7:0] idx, input int n);
    start_c();
    tx({srog_pkg::SLAVE_ADDR, 1'b0});
    tx(idx);
    start_c();
    tx({srog_pkg::SLAVE_ADDR, 1'b1});
    for (int k = 0; k <= n; k++)
    begin
      rx(k == n, rx_buf[k]);
    end
    stop_c();
  endtask

  // Address that is not ours; no ack is expected
  task automatic foreign();
    start_c();
    tx(8'hA0);
    stop_c();
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the output gating control bytes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       sys_clk;
  logic       rstn;
  logic       smb_clk_pin;
  logic       smb_data_in;
  logic       smb_data_out;
  logic       smb_data_oe;
  logic       req_a_n;
  logic       req_c_n;
  logic [5:0] serial_ref_run;
  logic [1:0] graphics_run;
  logic [2:0] vsel;
  logic [3:0] fsel;
  int         errors;
  int         cmp_count;
  int         n0;

  srog_ctrl dut_u (
    .sys_clk             (sys_clk),
    .rstn                (rstn),
    .smb_clk_pin         (smb_clk_pin),
    .smb_data_in         (smb_data_in),
    .smb_data_out        (smb_data_out),
    .smb_data_oe         (smb_data_oe),
    .request_pin_a_n     (req_a_n),
    .request_pin_c_n     (req_c_n),
    .serial_ref_run      (serial_ref_run),
    .graphics_run        (graphics_run),
    .out_voltage_sel     (vsel),
    .serial_ref_freq_sel (fsel)
  );

  srog_host host_u (
    .sys_clk     (sys_clk),
    .dut_data_oe (smb_data_oe),
    .smb_clk_pin (smb_clk_pin),
    .smb_data_in (smb_data_in)
  );

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // Compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Outputs settle 3 cycles after a pin; 5 leaves margin
  task automatic outs(input logic [5:0] r, input logic [1:0] g);
    repeat (5) @(posedge sys_clk);
    chk("serial_ref_run", {2'h0, serial_ref_run}, {2'h0, r});
    chk("graphics_run", {6'h00, graphics_run}, {6'h00, g});
  endtask

  // Block read of three register bytes, count byte first
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] c, input logic [7:0] e0,
                       input logic [7:0] e1, input logic [7:0] e2);
    host_u.rd(idx, 3);
    chk("byte_count", host_u.rx_buf[0], c);
    chk("read_0", host_u.rx_buf[1], e0);
    chk("read_1", host_u.rx_buf[2], e1);
    chk("read_2", host_u.rx_buf[3], e2);
  endtask

  // Fields of the voltage and frequency byte
  task automatic fields(input logic [2:0] v, input logic [3:0] f);
    chk("voltage_sel", {5'h00, vsel}, {5'h00, v});
    chk("freq_sel", {4'h0, fsel}, {4'h0, f});
  endtask

  // Main sequence
  initial
  begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    req_a_n = 1'b1;
    req_c_n = 1'b1;
    errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    outs(6'h3F, 2'h3);
    fields(3'h5, 4'h0);
    rdchk(8'h03, 8'h09, 8'hFF, 8'h00, 8'hA0);
    host_u.wr(8'h08, 8'h03);
    rdchk(8'h03, 8'h03, 8'hFF, 8'h00, 8'hA0);
    // Enable bit positions, mapping off
    host_u.wr(8'h03, 8'h81);
    outs(6'h21, 2'h3);
    host_u.wr(8'h03, 8'h00);
    outs(6'h00, 2'h3);
    // Cleared enables beat asserted requests
    host_u.wr(8'h04, 8'hFF);
    req_a_n <= 1'b0;
    req_c_n <= 1'b0;
    outs(6'h00, 2'h3);
    rdchk(8'h03, 8'h03, 8'h0A, 8'hE7, 8'hA0);
    // Request gating with every writable mapping bit set
    host_u.wr(8'h03, 8'hFF);
    req_a_n <= 1'b1;
    req_c_n <= 1'b1;
    outs(6'h06, 2'h0);
    req_a_n <= 1'b0;
    outs(6'h3E, 2'h0);
    req_a_n <= 1'b1;
    req_c_n <= 1'b0;
    outs(6'h07, 2'h3);
    req_c_n <= 1'b1;
    // Pairs of mapping bits
    host_u.wr(8'h04, 8'h21);
    outs(6'h36, 2'h3);
    host_u.wr(8'h04, 8'h82);
    outs(6'h1F, 2'h2);
    host_u.wr(8'h04, 8'h5C);
    outs(6'h2F, 2'h1);
    // Voltage and frequency fields, reserved bit 4 stays 0
    host_u.wr(8'h05, 8'hFF);
    fields(3'h7, 4'hF);
    rdchk(8'h05, 8'h03, 8'hEF, 8'h00, 8'h00);
    host_u.wr(8'h05, 8'h4A);
    fields(3'h2, 4'hA);
    chk("acks", host_u.nacks[7:0], 8'h00);
    chk("data_out", {7'h00, smb_data_out}, 8'h00);
    // A foreign address is not acknowledged
    n0 = host_u.nacks;
    host_u.foreign();
    chk("foreign_nack", 8'(host_u.nacks - n0), 8'h01);
    // Reset in mid-run must bring back the default run outputs and voltage and frequency fields
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    outs(6'h3F, 2'h3);
    fields(3'h5, 4'h0);
    results();
  end

  // Hang guard, well above the cycles the main sequence needs
  initial
  begin
    repeat (95000) @(posedge sys_clk);
    errors++;
    results();
  end
endmodule
`default_nettype wire
